// ===== pkg/ssft_defines.vh
`ifndef SSFT_DEFINES_VH
`define SSFT_DEFINES_VH

// Header byte layout.
`define SSFT_HDR_RW        7
`define SSFT_HDR_BURST     6
`define SSFT_ADDR_W        6

// Serial address map.
`define SSFT_ADDR_STB_LO   6'h30
`define SSFT_ADDR_STB_HI   6'h3D
`define SSFT_ADDR_PA_TABLE 6'h3E
`define SSFT_ADDR_TX_FIFO  6'h3F

// Strobe addresses inside the strobe range.
`define SSFT_STB_RESET     6'h30
`define SSFT_STB_FSON      6'h31
`define SSFT_STB_XOFF      6'h32
`define SSFT_STB_CAL       6'h33
`define SSFT_STB_TX        6'h35
`define SSFT_STB_IDLE      6'h36
`define SSFT_STB_PWD       6'h39
`define SSFT_STB_FTX       6'h3B
`define SSFT_STB_NOP       6'h3D

// Main state codes shown in the status byte.
`define SSFT_ST_IDLE       3'h0
`define SSFT_ST_TX         3'h2
`define SSFT_ST_UNDERFLOW  3'h7

// Transfer phases.
`define SSFT_PH_HEADER     2'h0
`define SSFT_PH_FIFO       2'h1
`define SSFT_PH_TABLE      2'h2
`define SSFT_PH_SKIP       2'h3

// Sizes.
`define SSFT_FIFO_DEPTH    7'h40
`define SSFT_FIFO_AW       6
`define SSFT_FREE_SAT      7'h0F
`define SSFT_TABLE_LAST    3'h7
`define SSFT_BIT_LAST      3'h7

`endif

// ===== design/ssft_pin_sync.v
`timescale 1ns/100ps
module ssft_pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire clk,    // Core clock.
  input  wire reset,  // Asynchronous reset, active high.
  input  wire pin,    // Asynchronous pin level.
  output reg  level   // Filtered level in the clk domain.
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // A change is taken only once the second and third stages agree.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      level  <= RESET_VAL;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level <= s3_reg;
      end
    end
  end

endmodule // ssft_pin_sync

// ===== design/ssft_tx_fifo.v
`timescale 1ns/100ps
`include "ssft_defines.vh"
module ssft_tx_fifo (
  input  wire       clk,      // Core clock.
  input  wire       reset,    // Asynchronous reset, active high.
  input  wire       push,     // Store push_data when not full.
  input  wire [7:0] push_data,// Byte to store.
  input  wire       pop,      // Take one byte when not empty.
  input  wire       flush,    // Empty the FIFO; wins over push and pop.
  output reg  [7:0] rd_data,  // Byte taken by the last pop.
  output reg        rd_valid, // One-cycle pulse with rd_data.
  output reg        empty,    // No byte stored.
  output reg  [6:0] count     // Bytes stored.
);

  reg [7:0]               mem [0:63];
  reg [`SSFT_FIFO_AW-1:0] wr_ptr_reg;
  reg [`SSFT_FIFO_AW-1:0] rd_ptr_reg;
  wire                    do_push;
  wire                    do_pop;

  // Writes beyond a full FIFO are dropped; the master sees zero free first.
  assign do_push = push && (count != `SSFT_FIFO_DEPTH);
  assign do_pop  = pop && (count != 7'h00);

  always @(posedge clk) begin
    if (do_push && !flush) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= 6'h00;
      rd_ptr_reg <= 6'h00;
      count      <= 7'h00;
      empty      <= 1'b1;
      rd_data    <= 8'h00;
      rd_valid   <= 1'b0;
    end else if (flush) begin
      wr_ptr_reg <= 6'h00;
      rd_ptr_reg <= 6'h00;
      count      <= 7'h00;
      empty      <= 1'b1;
      rd_valid   <= 1'b0;
    end else begin
      rd_valid <= do_pop;
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 6'h01;
      end
      if (do_pop) begin
        rd_data    <= mem[rd_ptr_reg];
        rd_ptr_reg <= rd_ptr_reg + 6'h01;
      end
      if (do_push && !do_pop) begin
        count <= count + 7'h01;
        empty <= 1'b0;
      end else if (do_pop && !do_push) begin
        count <= count - 7'h01;
        empty <= (count == 7'h01);
      end
    end
  end

endmodule // ssft_tx_fifo

// ===== design/ssft_spi_slave.v
`timescale 1ns/100ps
`include "ssft_defines.vh"
// Operation
// - Header-only strobe byte starts an internal sequence.
// - Status byte shifts out during strobe header.
// - Next header may follow a strobe directly.
// - Power-down and oscillator-off wait for deselect.
// - Write-only 64-byte transmit FIFO at one address.
// - Single FIFO write: header, one byte.
// - Burst FIFO write pushes bytes until deselect.
// - Free count reported before byte is stored.
// - Flush honoured only in idle or underflow.
// - Sleep entry empties the transmit FIFO.
// - Eight-entry power table, 3-bit selection field.
// - FSK uses entry zero; keying uses entries zero and one.
// - Table index wraps, cleared while deselected.
// - Burst bit and read/write bit steer table.
// - Sleep entry clears the power table.
// - Shared pin: tristate, status, or serial output.
// - Status pin zero feeds serial transmit data.
// - Header: read/write, burst, six-bit address, MSB first.
// - Status: ready flag, state, saturated free count.
// - Underflow state holds until flush strobe.
// - Deselect mid-byte cancels without side effects.
module ssft_spi_slave (
  input  wire       clk,             // Core clock, 10 MHz.
  input  wire       reset,           // Asynchronous reset, active high.
  input  wire       sclk,            // Serial clock pin.
  input  wire       chip_select_n,   // Chip select pin, active low.
  input  wire       si,              // Serial data input pin.
  output reg        so_out,          // Shared serial output pin, driven level.
  output reg        so_oe,           // Shared serial output pin, enable.
  input  wire       status_pin_zero, // First status pin, transmit data input.
  input  wire       chip_ready_n,    // Core: crystal not yet running.
  input  wire [2:0] main_state,      // Core: main state code.
  input  wire       tx_underflow,    // Core: pulse, FIFO ran dry in transmit.
  input  wire       sleep_enter,     // Core: pulse, entering sleep.
  input  wire       serial_mode,     // Core: serial transmit mode selected.
  input  wire       pin_one_enable,  // Core: shared pin programmed as status.
  input  wire       pin_one_level,   // Core: status level for shared pin.
  input  wire       on_off_keying,   // Core: on-off keying selected.
  input  wire       keying_symbol,   // Core: current keying symbol.
  input  wire [2:0] pa_table_select, // Core: front_end_config selection field.
  input  wire       fifo_pop,        // Core: take one byte from the FIFO.
  output wire [7:0] fifo_rd_data,    // Byte taken by fifo_pop.
  output wire       fifo_rd_valid,   // Pulse with fifo_rd_data.
  output wire       fifo_empty,      // FIFO holds no byte.
  output reg        strobe_valid,    // Pulse, strobe to execute.
  output reg  [5:0] strobe_code,     // Address of that strobe.
  output reg        serial_tx_data,  // Serial transmit data to modulator.
  output reg  [7:0] pa_setting,      // Power setting in use.
  output reg        underflow_state  // Underflow held until flushed.
);

  wire       sclk_f;
  wire       cs_n_f;
  wire       si_f;
  wire       pin_zero_f;
  reg        sclk_d_reg;
  reg        cs_n_d_reg;
  reg  [2:0] bit_cnt_reg;
  reg  [6:0] rx_sr_reg;
  reg  [7:0] tx_sr_reg;
  reg  [1:0] phase_reg;
  reg        burst_reg;
  reg        rw_reg;
  reg  [2:0] idx_reg;
  reg        defer_pwd_reg;
  reg        defer_xoff_reg;
  reg  [7:0] pa_table [0:7];
  wire [6:0] fifo_count;
  integer    i;

  function [3:0] sat_free;
    input [6:0] cnt;
    reg   [6:0] free;
    begin
      free = `SSFT_FIFO_DEPTH - cnt;
      sat_free = (free > `SSFT_FREE_SAT) ? 4'hF : free[3:0];
    end
  endfunction

  function is_strobe;
    input [5:0] a;
    begin
      case (a)
        `SSFT_STB_RESET, `SSFT_STB_FSON, `SSFT_STB_XOFF,
        `SSFT_STB_CAL, `SSFT_STB_TX, `SSFT_STB_IDLE,
        `SSFT_STB_PWD, `SSFT_STB_FTX, `SSFT_STB_NOP: is_strobe = 1'b1;
        default: is_strobe = 1'b0;
      endcase
    end
  endfunction

  ssft_pin_sync #(.RESET_VAL(1'b0)) u_sync_sclk (
    .clk   (clk),
    .reset (reset),
    .pin   (sclk),
    .level (sclk_f)
  );
  ssft_pin_sync #(.RESET_VAL(1'b1)) u_sync_cs_n (
    .clk   (clk),
    .reset (reset),
    .pin   (chip_select_n),
    .level (cs_n_f)
  );
  ssft_pin_sync #(.RESET_VAL(1'b0)) u_sync_si (
    .clk   (clk),
    .reset (reset),
    .pin   (si),
    .level (si_f)
  );
  ssft_pin_sync #(.RESET_VAL(1'b0)) u_sync_pin_zero (
    .clk   (clk),
    .reset (reset),
    .pin   (status_pin_zero),
    .level (pin_zero_f)
  );

  wire       sclk_rise = sclk_f & ~sclk_d_reg & ~cs_n_f;
  wire       sclk_fall = ~sclk_f & sclk_d_reg & ~cs_n_f;
  wire       cs_fall   = ~cs_n_f & cs_n_d_reg;
  wire       cs_rise   = cs_n_f & ~cs_n_d_reg;
  wire       byte_done = sclk_rise && (bit_cnt_reg == `SSFT_BIT_LAST);
  wire [7:0] rx_byte   = {rx_sr_reg, si_f};
  wire [5:0] hdr_addr  = rx_byte[`SSFT_ADDR_W-1:0];
  wire       hdr_rw    = rx_byte[`SSFT_HDR_RW];
  wire       hdr_burst = rx_byte[`SSFT_HDR_BURST];
  wire       in_header = (phase_reg == `SSFT_PH_HEADER);
  wire       hdr_done  = byte_done && in_header;
  wire       strobe_hit = hdr_done && !hdr_burst && is_strobe(hdr_addr);
  wire       flush_ok  = (main_state == `SSFT_ST_IDLE) || underflow_state;
  wire       flush_stb = strobe_hit && (hdr_addr == `SSFT_STB_FTX) && flush_ok;
  wire       deferred  = (hdr_addr == `SSFT_STB_PWD) || (hdr_addr == `SSFT_STB_XOFF);
  wire       fifo_push = byte_done && (phase_reg == `SSFT_PH_FIFO);
  wire       fifo_flush = flush_stb || sleep_enter;
  wire [2:0] rep_state = underflow_state ? `SSFT_ST_UNDERFLOW : main_state;
  wire [7:0] status    = {chip_ready_n, rep_state, sat_free(fifo_count)};
  wire       tbl_read  = (phase_reg == `SSFT_PH_TABLE) && rw_reg;
  wire [7:0] load_val  = tbl_read ? pa_table[idx_reg] : status;
  // Only entry one is ever keyed in, and only when the selection allows it.
  wire [2:0] pa_index  = (on_off_keying && keying_symbol && (pa_table_select != 3'h0))
                         ? 3'h1 : 3'h0;

  ssft_tx_fifo u_tx_fifo (
    .clk       (clk),
    .reset     (reset),
    .push      (fifo_push),
    .push_data (rx_byte),
    .pop       (fifo_pop),
    .flush     (fifo_flush),
    .rd_data   (fifo_rd_data),
    .rd_valid  (fifo_rd_valid),
    .empty     (fifo_empty),
    .count     (fifo_count)
  );

  // Serial framing; partial bytes never act, so a mid-byte deselect is harmless.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_d_reg  <= 1'b0;
      cs_n_d_reg  <= 1'b1;
      bit_cnt_reg <= 3'h0;
      rx_sr_reg   <= 7'h00;
      tx_sr_reg   <= 8'h00;
      phase_reg   <= `SSFT_PH_HEADER;
      burst_reg   <= 1'b0;
      rw_reg      <= 1'b0;
      idx_reg     <= 3'h0;
    end else begin
      sclk_d_reg <= sclk_f;
      cs_n_d_reg <= cs_n_f;
      if (cs_n_f) begin
        bit_cnt_reg <= 3'h0;
        phase_reg   <= `SSFT_PH_HEADER;
        idx_reg     <= 3'h0;
      end else begin
        if (cs_fall) begin
          tx_sr_reg <= status;
        end
        if (sclk_fall && bit_cnt_reg == 3'h0) begin
          tx_sr_reg <= load_val;
        end
        if (sclk_rise) begin
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          rx_sr_reg   <= rx_byte[6:0];
        end
        if (hdr_done) begin
          burst_reg <= hdr_burst;
          rw_reg    <= hdr_rw;
          if (!hdr_burst && hdr_addr >= `SSFT_ADDR_STB_LO &&
              hdr_addr <= `SSFT_ADDR_STB_HI) begin
            phase_reg <= `SSFT_PH_HEADER;
          end else if (hdr_addr == `SSFT_ADDR_TX_FIFO && !hdr_rw) begin
            phase_reg <= `SSFT_PH_FIFO;
          end else if (hdr_addr == `SSFT_ADDR_PA_TABLE) begin
            phase_reg <= `SSFT_PH_TABLE;
          end else begin
            phase_reg <= `SSFT_PH_SKIP;
          end
        end else if (byte_done) begin
          if (!burst_reg) begin
            phase_reg <= `SSFT_PH_HEADER;
          end
          if (phase_reg == `SSFT_PH_TABLE) begin
            idx_reg <= idx_reg + 3'h1;
          end
        end
      end
    end
  end

  // Power table; the table is lost on sleep entry.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      for (i = 0; i < 8; i = i + 1) begin
        pa_table[i] <= 8'h00;
      end
    end else if (sleep_enter) begin
      for (i = 0; i < 8; i = i + 1) begin
        pa_table[i] <= 8'h00;
      end
    end else if (byte_done && phase_reg == `SSFT_PH_TABLE && !rw_reg) begin
      pa_table[idx_reg] <= rx_byte;
    end
  end

  // Strobes; power-down and oscillator-off are held until deselect.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      strobe_valid   <= 1'b0;
      strobe_code    <= 6'h00;
      defer_pwd_reg  <= 1'b0;
      defer_xoff_reg <= 1'b0;
    end else begin
      strobe_valid <= 1'b0;
      if (strobe_hit && deferred) begin
        if (hdr_addr == `SSFT_STB_PWD) begin
          defer_pwd_reg <= 1'b1;
        end else begin
          defer_xoff_reg <= 1'b1;
        end
      end else if (strobe_hit &&
                   (hdr_addr != `SSFT_STB_FTX || flush_ok)) begin
        strobe_valid <= 1'b1;
        strobe_code  <= hdr_addr;
      end else if (cs_rise && (defer_pwd_reg || defer_xoff_reg)) begin
        // Power-down wins if both were sent in one frame.
        strobe_valid   <= 1'b1;
        strobe_code    <= defer_pwd_reg ? `SSFT_STB_PWD : `SSFT_STB_XOFF;
        defer_pwd_reg  <= 1'b0;
        defer_xoff_reg <= 1'b0;
      end
    end
  end

  // Underflow is sticky; a new underflow in the flush cycle is kept.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      underflow_state <= 1'b0;
    end else if (tx_underflow) begin
      underflow_state <= 1'b1;
    end else if (flush_stb) begin
      underflow_state <= 1'b0;
    end
  end

  // Shared output pin and the other core-facing outputs.
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      so_out         <= 1'b0;
      so_oe          <= 1'b0;
      serial_tx_data <= 1'b0;
      pa_setting     <= 8'h00;
    end else begin
      so_oe <= ~cs_n_f | pin_one_enable;
      if (cs_n_f) begin
        so_out <= pin_one_level;
      end else if (sclk_fall) begin
        so_out <= (bit_cnt_reg == 3'h0) ? load_val[7] : tx_sr_reg[~bit_cnt_reg];
      end else if (bit_cnt_reg == 3'h0 && in_header && !sclk_f) begin
        so_out <= chip_ready_n;
      end
      serial_tx_data <= (serial_mode && main_state == `SSFT_ST_TX) ? pin_zero_f : 1'b0;
      pa_setting     <= pa_table[pa_index];
    end
  end

endmodule // ssft_spi_slave

// ===== bench/ssft_spi_master.sv
`timescale 1ns/100ps
module ssft_spi_master (
  input  wire clk,           // Core clock, for alignment.
  input  wire so,            // Device serial output.
  output reg  sclk,          // Serial clock.
  output reg  chip_select_n, // Frame select.
  output reg  si             // Serial data out.
);
  // The clock stands low between frames; si is inverted once released.
  initial begin
    sclk = 1'h0;
    chip_select_n = 1'h1;
    si = 1'h0;
  end
  task on;
    @(posedge clk) #1 chip_select_n = 1'h0;
    #1000;
  endtask
  task off;
    #1000 chip_select_n = 1'h1;
    si = ~si;
    #1000;
  endtask
  // The synchroniser delays the output, so bits are taken just before each fall.
  task xfer(input [7:0] tx, input int nb, output [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      si = tx[i];
      #400 sclk = 1'h1;
      #350 rx[i] = so;
      #50 sclk = 1'h0;
    end
    si = ~si;
    #400;
    if (tx == 8'h30 && nb == 8) begin
      repeat (20) if (so) #100;
    end
  endtask
endmodule // ssft_spi_master

// ===== bench/ssft_spi_slave_sva.sv
`timescale 1ns/100ps
module ssft_spi_slave_sva (
  input wire       clk,             // Core clock.
  input wire       reset,           // Async reset.
  input wire       chip_select_n,   // Frame select.
  input wire       so_out,          // Shared pin level.
  input wire       so_oe,           // Shared pin enable.
  input wire       pin_one_enable,  // Pin as status.
  input wire       pin_one_level,   // Status level.
  input wire       strobe_valid,    // Strobe pulse.
  input wire [5:0] strobe_code,     // Strobe address.
  input wire       tx_underflow,    // Underflow pulse.
  input wire       underflow_state, // Underflow held.
  input wire       sleep_enter,     // Sleep pulse.
  input wire       fifo_empty,      // FIFO empty.
  input wire [7:0] pa_setting,      // Power in use.
  input wire       serial_mode,     // Serial mode.
  input wire [2:0] main_state,      // Main state.
  input wire       status_pin_zero, // Data pin.
  input wire       serial_tx_data   // Modulator data.
);
  // Pins cross a synchroniser, so a level must stand eight cycles before outputs are judged.
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  oe_frame_a: assert property (
    !chip_select_n [*8] |-> so_oe) else $error("pin idle in frame");
  // The pin outputs are registered, so they follow the core levels one cycle late.
  pin_level_a: assert property (
    (chip_select_n && $stable(pin_one_level)) [*8] |-> so_oe == $past(pin_one_enable)
    && (!$past(pin_one_enable) || so_out == $past(pin_one_level)))
    else $error("status pin wrong");
  strobe_set_a: assert property (
    strobe_valid |-> strobe_code inside {6'h30, 6'h31, 6'h32, 6'h33, 6'h35, 6'h36,
    6'h39, 6'h3B, 6'h3D}) else $error("unknown strobe");
  strobe_deferred_a: assert property (
    strobe_valid && strobe_code inside {6'h32, 6'h39} |-> chip_select_n
    ) else $error("deferred strobe early");
  underflow_set_a: assert property (
    tx_underflow |=> underflow_state) else $error("underflow not held");
  underflow_clear_a: assert property (
    $fell(underflow_state) |-> ##[0:1] strobe_code == 6'h3B) else $error("underflow lost");
  sleep_flush_a: assert property (
    sleep_enter |-> ##[1:3] (fifo_empty && pa_setting == 8'h00)) else $error("sleep kept data");
  tx_data_a: assert property (
    (serial_mode && main_state == 3'h2 && $stable(status_pin_zero)) [*8]
    |-> serial_tx_data == status_pin_zero) else $error("tx data wrong");
  cover property (strobe_valid && strobe_code == 6'h39);
  cover property ($fell(underflow_state));
  cover property (sleep_enter);
endmodule // ssft_spi_slave_sva
bind ssft_spi_slave ssft_spi_slave_sva chk_u (.clk, .reset, .chip_select_n, .so_out,
  .so_oe, .pin_one_enable, .pin_one_level, .strobe_valid, .strobe_code, .tx_underflow,
  .underflow_state, .sleep_enter, .fifo_empty, .pa_setting, .serial_mode, .main_state,
  .status_pin_zero, .serial_tx_data);

// ===== bench/ssft_spi_slave_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin \
  num_checks++; \
  if ((a) !== (b)) begin \
    failures++; \
    $display("wrong value at %0t: got %0h want %0h", $time, a, b); \
  end \
end
module ssft_spi_slave_tb;
  logic       clk = 1'h0, reset = 1'h1, chip_ready_n = 1'h0, tx_underflow = 1'h0;
  logic       sleep_enter = 1'h0, serial_mode = 1'h0, pin_one_enable = 1'h0;
  logic       pin_one_level = 1'h0, on_off_keying = 1'h0, keying_symbol = 1'h0;
  logic       fifo_pop = 1'h0, status_pin_zero = 1'h0, uf = 1'h0;
  logic [2:0] main_state = 3'h0, pa_table_select = 3'h0;
  logic [7:0] rx, d, last, t[8], q[$];
  logic [7:0] codes[8] = '{8'h30, 8'h31, 8'h33, 8'h35, 8'h36, 8'h3D, 8'h32, 8'h39};
  wire        sclk, chip_select_n, si, so_out, so_oe, fifo_rd_valid, fifo_empty;
  wire        strobe_valid, serial_tx_data, underflow_state;
  wire  [7:0] fifo_rd_data, pa_setting;
  wire  [5:0] strobe_code;
  int         failures = 0, num_checks = 0, pulses = 0, cyc = 0, k;
  ssft_spi_slave dut_u (.clk, .reset, .sclk, .chip_select_n, .si, .so_out, .so_oe,
    .status_pin_zero, .chip_ready_n, .main_state, .tx_underflow, .sleep_enter,
    .serial_mode, .pin_one_enable, .pin_one_level, .on_off_keying, .keying_symbol,
    .pa_table_select, .fifo_pop, .fifo_rd_data, .fifo_rd_valid, .fifo_empty,
    .strobe_valid, .strobe_code, .serial_tx_data, .pa_setting, .underflow_state);
  ssft_spi_master mst_u (.clk, .so(so_out), .sclk, .chip_select_n, .si);
  always #50 clk = ~clk;
  // The whole run needs about 8000 cycles; 20000, over twice that, means a hang.
  always @(posedge clk) begin
    if (strobe_valid) begin
      pulses++;
      last = 8'(strobe_code);
    end
    if (++cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  function automatic [7:0] stat(input int used);
    stat = {chip_ready_n, uf ? 3'h7 : main_state, used > 48 ? 4'(64 - used) : 4'hF};
  endfunction
  task sx(input [7:0] b);
    mst_u.xfer(b, 8, rx);
  endtask
  task automatic pls(ref logic s);
    @(posedge clk) #1 s = 1'h1;
    @(posedge clk) #1 s = 1'h0;
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h8285));
    repeat (10) @(posedge clk);
    #1 reset = 1'h0;
    #500;
    `CHK(pa_setting, 8'h00)
    foreach (codes[j]) begin
      main_state = 3'($urandom_range(0, 6));
      k = pulses;
      mst_u.on();
      sx(codes[j]);
      `CHK(rx, stat(0))
      #1000;
      `CHK(pulses - k, (codes[j] == 8'h32 || codes[j] == 8'h39) ? 0 : 1)
      mst_u.off();
      `CHK(last, codes[j])
    end
    $display("strobe test done");
    main_state = 3'h0;
    d = 8'($urandom);
    q.push_back(d);
    mst_u.on();
    sx(8'h3F);
    sx(d);
    sx(8'h3D);
    `CHK(rx, stat(1))
    sx(8'h7F);
    `CHK(rx, stat(1))
    for (int n = 1; n < 65; n++) begin
      d = 8'($urandom);
      if (n < 64) q.push_back(d);
      sx(d);
      `CHK(rx, stat(n))
    end
    mst_u.off();
    foreach (q[j]) begin
      pls(fifo_pop);
      `CHK(fifo_rd_valid, 1'h1)
      `CHK(fifo_rd_data, q[j])
    end
    `CHK(fifo_empty, 1'h1)
    $display("fifo test done");
    k = pulses;
    mst_u.on();
    sx(8'h3F);
    mst_u.xfer(8'hA5, 4, rx);
    mst_u.off();
    mst_u.on();
    mst_u.xfer(8'h36, 5, rx);
    mst_u.off();
    `CHK(fifo_empty, 1'h1)
    `CHK(pulses, k)
    mst_u.on();
    sx(8'h3F);
    sx(8'h5A);
    main_state = 3'h2;
    sx(8'h3B);
    mst_u.off();
    `CHK(fifo_empty, 1'h0)
    pls(tx_underflow);
    uf = 1'h1;
    mst_u.on();
    sx(8'h3B);
    `CHK(rx, stat(1))
    mst_u.off();
    uf = 1'h0;
    `CHK(underflow_state, 1'h0)
    `CHK(fifo_empty, 1'h1)
    $display("flush test done");
    mst_u.on();
    sx(8'h7E);
    for (int i = 0; i < 9; i++) begin
      t[i % 8] = 8'($urandom);
      sx(t[i % 8]);
    end
    mst_u.off();
    mst_u.on();
    sx(8'hFE);
    for (int i = 0; i < 8; i++) begin
      sx(8'h00);
      `CHK(rx, t[i])
    end
    mst_u.off();
    `CHK(pa_setting, t[0])
    on_off_keying = 1'h1;
    keying_symbol = 1'h1;
    pa_table_select = 3'h1;
    #300;
    `CHK(pa_setting, t[1])
    keying_symbol = 1'h0;
    #300;
    `CHK(pa_setting, t[0])
    d = 8'($urandom);
    mst_u.on();
    sx(8'h3E);
    sx(d);
    sx(8'h3F);
    sx(d);
    mst_u.off();
    mst_u.on();
    sx(8'hBE);
    sx(8'h00);
    mst_u.off();
    `CHK(rx, d)
    pls(sleep_enter);
    #300;
    `CHK(fifo_empty, 1'h1)
    `CHK(pa_setting, 8'h00)
    $display("table test done");
    serial_mode = 1'h1;
    pin_one_enable = 1'h1;
    for (int i = 0; i < 6; i++) begin
      pin_one_level = 1'($urandom);
      status_pin_zero = 1'($urandom);
      #800;
      `CHK(so_out, pin_one_level)
      `CHK(so_oe, 1'h1)
      `CHK(serial_tx_data, status_pin_zero)
    end
    pin_one_enable = 1'h0;
    #800;
    `CHK(so_oe, 1'h0)
    $display("pin test done");
    print_verdict();
  end
endmodule // ssft_spi_slave_tb
